/* File: src/tcpwm_params.svh */
// Register offsets, field positions and reset values of the timer unit
`ifndef TCPWM_PARAMS_SVH
`define TCPWM_PARAMS_SVH

`define TCPWM_OFS_CTRL 8'h00
`define TCPWM_OFS_PERIOD 8'h04
`define TCPWM_OFS_COMPARE 8'h08
`define TCPWM_OFS_COUNT 8'h0C
`define TCPWM_OFS_CAPTURE 8'h10
`define TCPWM_OFS_DEADBAND 8'h14
`define TCPWM_OFS_STATUS 8'h18
`define TCPWM_OFS_MASK 8'h1C
`define TCPWM_OFS_CMD 8'h20
`define TCPWM_OFS_UNMAPPED 8'hFF

`define TCPWM_CTRL_MODE_LSB 0
`define TCPWM_CTRL_CMP_LSB 2
`define TCPWM_CTRL_CLK_LSB 5
`define TCPWM_CTRL_COMP_BIT 7

`define TCPWM_EVT_TC 0
`define TCPWM_EVT_CMP 1
`define TCPWM_EVT_CAP 2
`define TCPWM_STAT_RUN 3

`define TCPWM_CMD_START 0
`define TCPWM_CMD_STOP 1

`define TCPWM_RST_PERIOD 16'hFFFF
`define TCPWM_RST_COMPARE 16'h8000
`define TCPWM_RST_DEAD 8'h00
`define TCPWM_RST_EVT 3'h0
`define TCPWM_RST_PRESCALE 16'h0004

`endif

/* File: src/tcpwm_pkg.sv */
// Types shared by the timer unit modules
package tcpwm_pkg;
   typedef logic [31:0] tcpwm_word_t;
   typedef logic [15:0] tcpwm_count_t;
   typedef enum logic [1:0] {
      MODE_FREE = 2'h0,
      MODE_ONESHOT = 2'h1,
      MODE_ENABLE = 2'h2,
      MODE_SPARE = 2'h3
   } tcpwm_mode_t;
   typedef enum logic [2:0] {
      BELOW_COMPARE = 3'h0,
      BELOW_OR_AT_COMPARE = 3'h1,
      AT_COMPARE = 3'h2,
      ABOVE_OR_AT_COMPARE = 3'h3,
      ABOVE_COMPARE = 3'h4
   } tcpwm_cmp_t;
   typedef enum logic [1:0] {
      CLK_SYS = 2'h0,
      CLK_DIV = 2'h1,
      CLK_EXT_A = 2'h2,
      CLK_EXT_B = 2'h3
   } tcpwm_clk_t;
   typedef enum logic [2:0] {
      DB_DEAD = 3'b001,
      DB_ON_P = 3'b010,
      DB_ON_N = 3'b100
   } tcpwm_db_state_t;
endpackage : tcpwm_pkg

/* File: src/tcpwm_ahb_slave.sv */
// AHB-Lite slave front end of the timer unit register file
`include "tcpwm_params.svh"

module tcpwm_ahb_slave (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // AHB-Lite slave side
   input wire logic hsel,
   input wire tcpwm_pkg::tcpwm_word_t haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire tcpwm_pkg::tcpwm_word_t hwdata,
   output logic hreadyout,
   output tcpwm_pkg::tcpwm_word_t hrdata,
   output logic hresp,
   // Register file side
   output logic regWrite,
   output logic [7:0] regAddr,
   output tcpwm_pkg::tcpwm_word_t regWdata,
   input wire tcpwm_pkg::tcpwm_word_t regRdata
);
   import tcpwm_pkg::*;

   logic accept;
   logic wordSize;
   logic inWindow;
   logic pendWrite;
   logic pendRead;

   assign wordSize = (hsize == 3'h2);
   assign inWindow = (haddr[31:8] == 24'h000000);
   assign accept = hsel & htrans[1] & hready & hreadyout;
   assign regWrite = pendWrite;
   assign regWdata = hwdata;

   // Reads take one wait state so that hrdata leaves a flop and a write
   // in the preceding data phase is already visible
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pendWrite <= 1'b0;
         pendRead <= 1'b0;
         regAddr <= `TCPWM_OFS_UNMAPPED;
         hreadyout <= 1'b1;
         hrdata <= 32'h00000000;
         hresp <= 1'b0;
      end else begin
         pendWrite <= accept & hwrite & wordSize;
         hresp <= 1'b0;
         if (accept) begin
            regAddr <= inWindow ? haddr[7:0] : `TCPWM_OFS_UNMAPPED;
         end
         if (accept & !hwrite) begin
            pendRead <= 1'b1;
            hreadyout <= 1'b0;
         end else if (pendRead) begin
            pendRead <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= regRdata;
         end
      end
   end
endmodule : tcpwm_ahb_slave

/* File: src/tcpwm_deadband.sv */
// Complementary output generator with a programmable dead interval
module tcpwm_deadband #(
   parameter int DEAD_W = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Counting clock and raw comparator level
   input wire logic tick,
   input wire logic rawIn,
   input wire logic [DEAD_W-1:0] deadTicks,
   // Complementary pair
   output logic posOut,
   output logic negOut
);
   import tcpwm_pkg::*;

   tcpwm_db_state_t state;
   tcpwm_db_state_t next_state;
   logic [DEAD_W-1:0] cnt;
   logic noDead;
   logic deadDone;

   assign noDead = (deadTicks == '0);
   assign deadDone = tick & (cnt <= DEAD_W'(1));
   // One state per level, so the two can never be high together
   assign posOut = (state == DB_ON_P);
   assign negOut = (state == DB_ON_N);

   always_comb begin
      next_state = state;
      unique case (state)
         DB_ON_P: begin
            if (!rawIn) begin
               next_state = noDead ? DB_ON_N : DB_DEAD;
            end
         end
         DB_ON_N: begin
            if (rawIn) begin
               next_state = noDead ? DB_ON_P : DB_DEAD;
            end
         end
         DB_DEAD: begin
            if (deadDone) begin
               next_state = rawIn ? DB_ON_P : DB_ON_N;
            end
         end
         default: next_state = DB_DEAD;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= DB_DEAD;
         cnt <= '0;
      end else begin
         state <= next_state;
         if (state != DB_DEAD && next_state == DB_DEAD) begin
            cnt <= deadTicks;
         end else if (state == DB_DEAD && tick && cnt != '0) begin
            cnt <= cnt - DEAD_W'(1);
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence seqPosDrops;
      posOut && !rawIn && !noDead;
   endsequence

   AST_DEAD_GAP: assert property (
      seqPosDrops |=> !posOut && !negOut && cnt == $past(deadTicks))
      else $error("dead interval not entered after positive output fell");
endmodule : tcpwm_deadband

/* File: src/tcpwm_core.sv */
// Timer, counter and pulse-width unit with AHB-Lite registers
//
// Local design decisions: the address map and the AHB-Lite register port.
`include "tcpwm_params.svh"

// Operation
// - 16-bit counter that only counts down
// - Counting tick chosen from several clock sources
// - Comparator modes: below, at or above compare
// - Reload period on start, reset input, terminal count
// - Interrupt on terminal count, compare, capture
// - Capture input latches full count for software
// - Timer reset and capture inputs provided
// - Compare, terminal count, interrupt, complementary outputs
// - Free-running mode reloads and keeps counting
// - One-shot mode halts after single period
// - Enable mode counts only while enable high
// - Complementary outputs never active together
// - Kill input forces compare outputs inactive
module tcpwm_core #(
   parameter logic [15:0] PRESCALE = `TCPWM_RST_PRESCALE,
   parameter int DEAD_W = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // AHB-Lite register bus
   input wire logic hsel,
   input wire tcpwm_pkg::tcpwm_word_t haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire tcpwm_pkg::tcpwm_word_t hwdata,
   output logic hreadyout,
   output tcpwm_pkg::tcpwm_word_t hrdata,
   output logic hresp,
   // Timer inputs from the routing fabric
   input wire logic tickInA,
   input wire logic tickInB,
   input wire logic timerResetIn,
   input wire logic captureIn,
   input wire logic enableIn,
   input wire logic killIn,
   // Timer outputs
   output logic cmpOut,
   output logic cmpOutN,
   output logic tcOut,
   output logic irq
);
   import tcpwm_pkg::*;

   logic regWrite;
   logic [7:0] regAddr;
   tcpwm_word_t regWdata;
   tcpwm_word_t regRdata;

   tcpwm_mode_t mode;
   tcpwm_cmp_t cmpMode;
   tcpwm_clk_t clkSel;
   logic compEn;
   tcpwm_count_t period;
   tcpwm_count_t compare;
   tcpwm_count_t count;
   tcpwm_count_t capture;
   logic [DEAD_W-1:0] deadTicks;
   logic [2:0] status;
   logic [2:0] mask;
   logic running;

   logic [15:0] divCnt;
   logic tickAPrev;
   logic tickBPrev;
   logic rstPrev;
   logic capPrev;
   logic cmpPrev;

   tcpwm_count_t next_count;
   logic next_running;
   logic [2:0] next_status;
   logic [2:0] next_mask;

   tcpwm_ahb_slave u_bus (
      .sys_clk(sys_clk),
      .reset(reset),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .hwdata(hwdata),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .hresp(hresp),
      .regWrite(regWrite),
      .regAddr(regAddr),
      .regWdata(regWdata),
      .regRdata(regRdata)
   );

   // Write decode
   logic wrCtrl;
   logic wrPeriod;
   logic wrCompare;
   logic wrDead;
   logic wrStatus;
   logic wrMask;
   logic wrCmd;
   assign wrCtrl = regWrite & (regAddr == `TCPWM_OFS_CTRL);
   assign wrPeriod = regWrite & (regAddr == `TCPWM_OFS_PERIOD);
   assign wrCompare = regWrite & (regAddr == `TCPWM_OFS_COMPARE);
   assign wrDead = regWrite & (regAddr == `TCPWM_OFS_DEADBAND);
   assign wrStatus = regWrite & (regAddr == `TCPWM_OFS_STATUS);
   assign wrMask = regWrite & (regAddr == `TCPWM_OFS_MASK);
   assign wrCmd = regWrite & (regAddr == `TCPWM_OFS_CMD);

   logic startReq;
   logic stopReq;
   assign startReq = wrCmd & regWdata[`TCPWM_CMD_START];
   assign stopReq = wrCmd & regWdata[`TCPWM_CMD_STOP];

   // Counting tick selection
   logic divTick;
   logic tickARise;
   logic tickBRise;
   logic tick;
   assign divTick = (divCnt == 16'h0000);
   assign tickARise = tickInA & !tickAPrev;
   assign tickBRise = tickInB & !tickBPrev;
   assign tick = (clkSel == CLK_SYS) |
                 ((clkSel == CLK_DIV) & divTick) |
                 ((clkSel == CLK_EXT_A) & tickARise) |
                 ((clkSel == CLK_EXT_B) & tickBRise);

   // Reset and capture inputs act on their rising edge
   logic rstEdge;
   logic capEdge;
   assign rstEdge = timerResetIn & !rstPrev;
   assign capEdge = captureIn & !capPrev;

   // Counting core
   logic gate;
   logic step;
   logic atZero;
   logic tcEvent;
   logic tcLevel;
   assign gate = (mode != MODE_ENABLE) | enableIn;
   assign step = running & tick & gate;
   assign atZero = (count == 16'h0000);
   assign tcEvent = step & atZero;
   assign tcLevel = running & atZero;
   // Zero lasts one tick, the reload happens on the tick after it
   assign next_count = (startReq | rstEdge) ? period :
                       !step ? count :
                       !atZero ? count - 16'h0001 :
                       (mode == MODE_ONESHOT) ? count :
                       period;
   assign next_running = stopReq ? 1'b0 :
                         startReq ? 1'b1 :
                         (tcEvent & (mode == MODE_ONESHOT)) ? 1'b0 :
                         running;

   // Comparator
   function automatic logic cmpMatch(input tcpwm_count_t cnt,
                                     input tcpwm_count_t ref_val,
                                     input tcpwm_cmp_t sel);
      logic res;
      res = 1'b0;
      unique case (sel)
         BELOW_COMPARE: res = (cnt < ref_val);
         BELOW_OR_AT_COMPARE: res = (cnt <= ref_val);
         AT_COMPARE: res = (cnt == ref_val);
         ABOVE_OR_AT_COMPARE: res = (cnt >= ref_val);
         ABOVE_COMPARE: res = (cnt > ref_val);
         default: res = 1'b0;
      endcase
      return res;
   endfunction : cmpMatch

   logic cmpTrue;
   logic cmpEvent;
   assign cmpTrue = running & cmpMatch(count, compare, cmpMode);
   assign cmpEvent = cmpTrue & !cmpPrev;

   // Complementary pair follows the raw compare with a dead gap
   logic dbPos;
   logic dbNeg;
   tcpwm_deadband #(
      .DEAD_W(DEAD_W)
   ) u_dead (
      .sys_clk(sys_clk),
      .reset(reset),
      .tick(tick),
      .rawIn(cmpTrue),
      .deadTicks(deadTicks),
      .posOut(dbPos),
      .negOut(dbNeg)
   );

   // Events and interrupt; a new event wins over a clear in the same cycle
   logic [2:0] events;
   logic [2:0] statusClr;
   assign events = {capEdge, cmpEvent, tcEvent};
   assign statusClr = wrStatus ? regWdata[2:0] : 3'h0;
   assign next_status = (status & ~statusClr) | events;
   assign next_mask = wrMask ? regWdata[2:0] : mask;

   logic drive;
   assign drive = running & !killIn;

   // Read mux; count is sampled in one cycle so a read is always coherent
   tcpwm_word_t ctrlWord;
   assign ctrlWord = {24'h000000, compEn, clkSel, cmpMode, mode};
   assign regRdata =
      (regAddr == `TCPWM_OFS_CTRL) ? ctrlWord :
      (regAddr == `TCPWM_OFS_PERIOD) ? {16'h0000, period} :
      (regAddr == `TCPWM_OFS_COMPARE) ? {16'h0000, compare} :
      (regAddr == `TCPWM_OFS_COUNT) ? {16'h0000, count} :
      (regAddr == `TCPWM_OFS_CAPTURE) ? {16'h0000, capture} :
      (regAddr == `TCPWM_OFS_DEADBAND) ? 32'(deadTicks) :
      (regAddr == `TCPWM_OFS_STATUS) ? {28'h0000000, running, status} :
      (regAddr == `TCPWM_OFS_MASK) ? {29'h0000000, mask} :
      32'h00000000;

   // Configuration registers
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mode <= MODE_FREE;
         cmpMode <= BELOW_COMPARE;
         clkSel <= CLK_SYS;
         compEn <= 1'b0;
         period <= `TCPWM_RST_PERIOD;
         compare <= `TCPWM_RST_COMPARE;
         deadTicks <= DEAD_W'(`TCPWM_RST_DEAD);
      end else begin
         if (wrCtrl) begin
            mode <= tcpwm_mode_t'(regWdata[`TCPWM_CTRL_MODE_LSB +: 2]);
            cmpMode <= tcpwm_cmp_t'(regWdata[`TCPWM_CTRL_CMP_LSB +: 3]);
            clkSel <= tcpwm_clk_t'(regWdata[`TCPWM_CTRL_CLK_LSB +: 2]);
            compEn <= regWdata[`TCPWM_CTRL_COMP_BIT];
         end
         if (wrPeriod) begin
            period <= regWdata[15:0];
         end
         if (wrCompare) begin
            compare <= regWdata[15:0];
         end
         if (wrDead) begin
            deadTicks <= regWdata[DEAD_W-1:0];
         end
      end
   end

   // Prescaler and input edge history
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         divCnt <= 16'h0000;
         tickAPrev <= 1'b0;
         tickBPrev <= 1'b0;
         rstPrev <= 1'b0;
         capPrev <= 1'b0;
         cmpPrev <= 1'b0;
      end else begin
         divCnt <= divTick ? PRESCALE - 16'h0001 : divCnt - 16'h0001;
         tickAPrev <= tickInA;
         tickBPrev <= tickInB;
         rstPrev <= timerResetIn;
         capPrev <= captureIn;
         cmpPrev <= cmpTrue;
      end
   end

   // Counter, capture, status and outputs
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         count <= `TCPWM_RST_PERIOD;
         running <= 1'b0;
         capture <= 16'h0000;
         status <= `TCPWM_RST_EVT;
         mask <= `TCPWM_RST_EVT;
         cmpOut <= 1'b0;
         cmpOutN <= 1'b0;
         tcOut <= 1'b0;
         irq <= 1'b0;
      end else begin
         count <= next_count;
         running <= next_running;
         if (capEdge) begin
            capture <= count;
         end
         status <= next_status;
         mask <= next_mask;
         cmpOut <= drive & (compEn ? dbPos : cmpTrue);
         cmpOutN <= drive & compEn & dbNeg;
         tcOut <= tcLevel;
         irq <= |(next_status & next_mask);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence seqQuiet;
      !startReq && !rstEdge && !stopReq;
   endsequence

   sequence seqTcFree;
      tcEvent && mode == MODE_FREE ##0 seqQuiet;
   endsequence

   sequence seqTcOneShot;
      tcEvent && mode == MODE_ONESHOT ##0 seqQuiet;
   endsequence

   AST_DOWN_ONLY: assert property (
      (step && !atZero) ##0 seqQuiet |=> count == $past(count) - 16'h0001)
      else $error("counter did not step down by one");

   AST_LOAD_ON_START: assert property (
      (startReq || rstEdge) && !stopReq |=> count == $past(period))
      else $error("period not loaded on start or reset input");

   AST_TC_RELOAD: assert property (
      seqTcFree |=> count == $past(period) && running)
      else $error("free-running counter did not reload at zero");

   AST_TC_PULSE: assert property (
      tcOut == $past(tcLevel))
      else $error("terminal count output does not track zero state");

   AST_ONESHOT_HALT: assert property (
      seqTcOneShot |=> (!running && atZero) ##1
      (!running || $past(startReq)))
      else $error("one-shot counter did not halt at end of period");

   AST_ENABLE_HOLD: assert property (
      (running && mode == MODE_ENABLE && !enableIn) ##0 seqQuiet
      |=> $stable(count))
      else $error("counter moved while enable was low");

   AST_CAPTURE: assert property (
      capEdge |=> capture == $past(count) && status[`TCPWM_EVT_CAP])
      else $error("capture did not latch the count");

   AST_KILL: assert property (
      killIn |=> !cmpOut && !cmpOutN)
      else $error("kill did not force outputs inactive");

   AST_NO_OVERLAP: assert property (
      !(cmpOut && cmpOutN))
      else $error("complementary outputs active together");

   AST_IRQ_TC: assert property (
      tcEvent && mask[`TCPWM_EVT_TC] && !wrMask
      |=> irq && status[`TCPWM_EVT_TC])
      else $error("terminal count did not raise the interrupt");

   AST_CMP_BELOW: assert property (
      running && cmpMode == BELOW_COMPARE |-> cmpTrue == (count < compare))
      else $error("below-compare result wrong");

   AST_TICK_DIV: assert property (
      running && clkSel == CLK_DIV && !divTick ##0 seqQuiet
      |=> $stable(count))
      else $error("counter moved without a divided tick");
endmodule : tcpwm_core

/* File: verif/tcpwm_fabric_model.sv */
// Routing-fabric model: two free-running external tick sources
module tcpwm_fabric_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Half periods of the sources, in sys_clk cycles
   input wire logic [3:0] halfA,
   input wire logic [3:0] halfB,
   // Tick sources, one tick per rising edge
   output logic tickInA,
   output logic tickInB
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cntA;
   logic [3:0] cntB;

   // Both sources free-run so their phase is unrelated to bus traffic
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cntA <= 4'h0;
         cntB <= 4'h0;
         tickInA <= 1'b0;
         tickInB <= 1'b0;
      end else begin
         cntA <= (cntA + 4'h1 == halfA) ? 4'h0 : cntA + 4'h1;
         cntB <= (cntB + 4'h1 == halfB) ? 4'h0 : cntB + 4'h1;
         if (cntA + 4'h1 == halfA) tickInA <= ~tickInA;
         if (cntB + 4'h1 == halfB) tickInB <= ~tickInB;
      end
   end
endmodule : tcpwm_fabric_model

/* File: verif/tb_timer_counter_pwm_unit.sv */
// Self-checking bench of the timer, counter and pulse-width unit
`include "tcpwm_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_timer_counter_pwm_unit;
   timeunit 1ns;
   timeprecision 1ps;
   import tcpwm_pkg::*;
   localparam logic [15:0] PRE = 16'h0003;
   localparam int HALF_A = 2;
   localparam int HALF_B = 3;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   tcpwm_word_t haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic hready;
   tcpwm_word_t hwdata = '0;
   logic hreadyout;
   tcpwm_word_t hrdata;
   logic hresp;
   logic tickInA;
   logic tickInB;
   logic timerResetIn = 1'b0;
   logic captureIn = 1'b0;
   logic enableIn = 1'b0;
   logic killIn = 1'b0;
   logic cmpOut;
   logic cmpOutN;
   logic tcOut;
   logic irq;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   int rdCyc;
   int gap, hp, hn, bo, c, p, t;
   int tk[4] = '{1, int'(PRE), 2 * HALF_A, 2 * HALF_B};
   tcpwm_word_t rv, rv2;

   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;

   tcpwm_core #(.PRESCALE(PRE), .DEAD_W(8)) tcpwm_core_inst (
      .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .tickInA(tickInA), .tickInB(tickInB),
      .timerResetIn(timerResetIn), .captureIn(captureIn),
      .enableIn(enableIn), .killIn(killIn), .cmpOut(cmpOut),
      .cmpOutN(cmpOutN), .tcOut(tcOut), .irq(irq));

   tcpwm_fabric_model tcpwm_fabric_model_inst (
      .sys_clk(sys_clk), .reset(reset), .halfA(4'(HALF_A)),
      .halfB(4'(HALF_B)), .tickInA(tickInA), .tickInB(tickInB));

   always #5 sys_clk = ~sys_clk;

   task stop_test;
      if (err_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         stop_test();
      end
   end

   task bus(input logic w, input logic [7:0] o, input tcpwm_word_t wd,
            input logic [2:0] sz, output tcpwm_word_t d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, o};
      hwrite <= w;
      hsize <= sz;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      d = hrdata;
      rdCyc = cyc;
   endtask : bus

   task wr(input logic [7:0] o, input tcpwm_word_t v);
      tcpwm_word_t x;
      bus(1'b1, o, v, 3'h2, x);
   endtask : wr

   task rd(input logic [7:0] o, output tcpwm_word_t d);
      bus(1'b0, o, '0, 3'h2, d);
   endtask : rd

   task strobe(input int cap);
      if (cap != 0) captureIn <= 1'b1;
      else timerResetIn <= 1'b1;
      @(posedge sys_clk);
      captureIn <= 1'b0;
      timerResetIn <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask : strobe

   // Counts cycles and output highs between two rises of tcOut
   task measure(output int g, output int hi, output int lo, output int b);
      int rises;
      logic prev;
      rises = 0;
      g = 0;
      hi = 0;
      lo = 0;
      b = 0;
      prev = 1'b1;
      for (int i = 0; i < 4000 && rises < 2; i++) begin
         @(posedge sys_clk);
         if (rises == 1) begin
            g++;
            hi += int'(cmpOut === 1'b1);
            lo += int'(cmpOutN === 1'b1);
            b += int'(cmpOut === 1'b1 && cmpOutN === 1'b1);
         end
         if (tcOut === 1'b1 && prev !== 1'b1) rises++;
         prev = tcOut;
      end
   endtask : measure

   // Expected compare-high ticks over one period counting p down to 0
   function automatic int duty(int m, int cv, int pv);
      int n = 0;
      for (int v = 0; v <= pv; v++) begin
         case (m)
            0: n += int'(v < cv);
            1: n += int'(v <= cv);
            2: n += int'(v == cv);
            3: n += int'(v >= cv);
            4: n += int'(v > cv);
            default: n += 0;
         endcase
      end
      return n;
   endfunction : duty

   initial begin
      void'($urandom(32'h97F16FA7));
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      rd(`TCPWM_OFS_COUNT, rv);
      `CHK(rv, 32'h0000FFFF)
      rd(`TCPWM_OFS_COMPARE, rv);
      `CHK(rv, {16'h0000, `TCPWM_RST_COMPARE})
      rd(8'h40, rv);
      `CHK(rv, 32'h00000000)
      `CHK(hresp, 1'b0)
      wr(`TCPWM_OFS_PERIOD, 9);
      wr(`TCPWM_OFS_CMD, 1);
      // Every comparator mode plus an unused code, at a random threshold
      for (int m = 0; m < 6; m++) begin
         c = 1 + $urandom % 8;
         wr(`TCPWM_OFS_COMPARE, c);
         wr(`TCPWM_OFS_CTRL, m << 2);
         repeat (2) measure(gap, hp, hn, bo);
         `CHK(gap, 10)
         `CHK(hp, duty(m, c, 9))
         `CHK(hn, 0)
      end
      rd(`TCPWM_OFS_STATUS, rv);
      `CHK(rv[3:0], 4'hB)
      wr(`TCPWM_OFS_COMPARE, 5);
      wr(`TCPWM_OFS_CTRL, 0);
      killIn <= 1'b1;
      repeat (2) measure(gap, hp, hn, bo);
      `CHK(hp, 0)
      `CHK(gap, 10)
      killIn <= 1'b0;
      for (int d = 0; d < 4; d += 2) begin
         wr(`TCPWM_OFS_DEADBAND, d);
         wr(`TCPWM_OFS_CTRL, 32'h00000080);
         repeat (2) measure(gap, hp, hn, bo);
         `CHK(bo, 0)
         `CHK(hp + hn, 10 - 2 * d)
      end
      wr(`TCPWM_OFS_PERIOD, 4);
      for (int s = 1; s < 4; s++) begin
         wr(`TCPWM_OFS_CTRL, s << 5);
         repeat (2) measure(gap, hp, hn, bo);
         `CHK(gap, 5 * tk[s])
      end
      wr(`TCPWM_OFS_CMD, 2);
      wr(`TCPWM_OFS_PERIOD, 20);
      wr(`TCPWM_OFS_STATUS, 15);
      wr(`TCPWM_OFS_MASK, 1);
      wr(`TCPWM_OFS_CTRL, 32'h00000015);
      wr(`TCPWM_OFS_CMD, 1);
      repeat (40) @(posedge sys_clk);
      `CHK(irq, 1'b1)
      rd(`TCPWM_OFS_STATUS, rv);
      `CHK(rv[3:0], 4'h1)
      rd(`TCPWM_OFS_COUNT, rv);
      `CHK(rv, 32'h00000000)
      strobe(0);
      rd(`TCPWM_OFS_COUNT, rv);
      `CHK(rv, 32'h00000014)
      // Gated mode: start loads the period but nothing moves while low
      p = 500 + $urandom % 500;
      wr(`TCPWM_OFS_PERIOD, p);
      wr(`TCPWM_OFS_CTRL, 32'h00000016);
      wr(`TCPWM_OFS_CMD, 1);
      repeat (5) @(posedge sys_clk);
      rd(`TCPWM_OFS_COUNT, rv);
      `CHK(rv, 32'(p))
      enableIn <= 1'b1;
      rd(`TCPWM_OFS_COUNT, rv);
      t = rdCyc;
      rd(`TCPWM_OFS_COUNT, rv2);
      `CHK(rv - rv2, 32'(rdCyc - t))
      enableIn <= 1'b0;
      wr(`TCPWM_OFS_CMD, 2);
      strobe(0);
      wr(`TCPWM_OFS_STATUS, 15);
      wr(`TCPWM_OFS_MASK, 4);
      `CHK(irq, 1'b0)
      strobe(1);
      `CHK(irq, 1'b1)
      rd(`TCPWM_OFS_CAPTURE, rv);
      `CHK(rv, 32'(p))
      bus(1'b1, `TCPWM_OFS_PERIOD, 32'h7, 3'h1, rv);
      rd(`TCPWM_OFS_PERIOD, rv);
      `CHK(rv, 32'(p))
      wr(`TCPWM_OFS_STATUS, 4);
      @(posedge sys_clk);
      `CHK(irq, 1'b0)
      wr(`TCPWM_OFS_MASK, 0);
      strobe(1);
      `CHK(irq, 1'b0)
      rd(`TCPWM_OFS_STATUS, rv);
      `CHK(rv[3:0], 4'h4)
      stop_test();
   end
endmodule : tb_timer_counter_pwm_unit
